// ===== logic/cfmat_consts.svh
// constants for the clock fail monitor and auto trim block
// assumes a 200 MHz single clock domain and a classic wishbone slave
// Function
// - system clock failure sets shared fail flag and system fail status
// - fail flag high with its enable raises an interrupt request
// - system monitor forces source selections to internal hf oscillator
// - after failover stay on internal oscillator; never switch back alone
// - primary or secondary failure sets fail flag and matching status
// - primary or secondary failures never switch the system clock
// - each monitor has fault injection that blocks its sample input
// - system fault injection write switches clock and sets flags
// - primary/secondary injection write sets status and flag, no switch
// - fail-safe clears on reset, sleep (not while waiting on the startup timer), or source/divider request change
// - external switch restarts startup timer; clear after timer expires
// - software clears fail flag; persisting failure sets it again
// - crystal modes detect after startup timer; external clock mode at once
// - tuning measures hf oscillator against 32.768 kHz time base
// - tuning owns trim field; software writes ignored while enabled
// - lock flag set within 1 percent, cleared otherwise, read only
// - out-of-range set when trim at limit and beyond needed, read only
// - hold trim while out of range; clear flag when back in range
// - trim steps each tuning cycle unless locked, out of range, or update-disable is set
// - lock or range change sets tuning interrupt flag
// - tuning off and update-disable set blocks software trim writes
// - control: enable b7, update-disable b6, lock b3, range b1, reset 0
// - sample clock is lf oscillator divided by 64, half-period timeout
// - trim is six bit two's complement, 1F max, 00 center, 20 min
`ifndef CFMAT_CONSTS_SVH
`define CFMAT_CONSTS_SVH
`define CFMAT_ADR_ACT 8'hAC
`define CFMAT_ADR_TRIM 8'hB0
`define CFMAT_ADR_FAIL 8'hC0
`define CFMAT_ADR_SRC 8'hC4
`define CFMAT_ACT_EN 7
`define CFMAT_ACT_UD 6
`define CFMAT_ACT_LOCK 3
`define CFMAT_ACT_ORS 1
`define CFMAT_F_SYS 0
`define CFMAT_F_PRI 1
`define CFMAT_F_SEC 2
`define CFMAT_F_OSC_FAIL_IRQ_FLAG 3
`define CFMAT_F_OSC_FAIL_IRQ_ENABLE 4
`define CFMAT_F_AUTO_TRIM_IRQ_FLAG 5
`define CFMAT_F_AUTO_TRIM_IRQ_ENABLE 6
`define CFMAT_F_INJ 8
`define CFMAT_LF_DIV 6'h3F
`define CFMAT_SRC_HF 3'h6
`define CFMAT_SRC_EXT 3'h7
`define CFMAT_SRC_PLL 3'h2
`define CFMAT_TRIM_MAX 6'h1F
`define CFMAT_TRIM_MIN 6'h20
`define CFMAT_TRIM_RST 6'h00
`define CFMAT_REF_WIN 16'h0400
`define CFMAT_LOCK_TOL 16'h000A
`define CFMAT_OST_CYC 16'h0400
`endif

// ===== logic/cfmat_pkg.sv
// types for the clock fail monitor and auto trim block
// assumes the constants header is included by the design
package cfmat_pkg;
  typedef enum logic [1:0] {
    CFMAT_RUN = 2'b00,
    CFMAT_FAILED = 2'b01,
    CFMAT_WAIT_OST = 2'b11
  } cfmat_fs_type;
  typedef enum logic [1:0] {
    CFMAT_XT_LP = 2'b00,
    CFMAT_XT = 2'b01,
    CFMAT_XT_HS = 2'b11,
    CFMAT_XT_EC = 2'b10
  } cfmat_mode_type;
endpackage : cfmat_pkg

// ===== logic/cfmat_top.sv
// clock fail monitors with fail-safe switch, plus hf oscillator auto trim
// assumes clocks to be watched arrive as synchronous levels sampled on clk_i
`include "cfmat_consts.svh"
`timescale 1ns/1ps
module cfmat_top
  import cfmat_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic sysclk_i,
  input wire logic primary_ext_osc_i,
  input wire logic secondary_ext_osc_i,
  input wire logic internal_lf_osc_i,
  input wire logic internal_hf_osc_i,
  input wire logic sysclk_mon_en_i,
  input wire logic primary_mon_en_i,
  input wire logic secondary_mon_en_i,
  input wire logic [1:0] ext_osc_mode_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic [2:0] requested_source_sel_i,
  input wire logic [3:0] requested_divider_sel_i,
  input wire logic switch_done_i,
  output logic fsafe_force_hf_o,
  output logic [2:0] current_source_sel_o,
  output logic osc_fail_irq_o,
  output logic auto_trim_irq_o,
  output logic [5:0] hf_trim_field_o
);

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction : rose

  function automatic logic fell(input logic cur, input logic prev);
    fell = ~cur & prev;
  endfunction : fell

  logic req_wr;
  logic req_rd;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [2:0] inject_q;
  logic osc_fail_irq_flag_q;
  logic osc_fail_irq_enable_q;
  logic [2:0] fail_status_q;
  logic auto_trim_enable_q;
  logic auto_trim_update_disable_q;
  logic auto_trim_locked_q;
  logic auto_trim_out_of_range_q;
  logic auto_trim_irq_flag_q;
  logic auto_trim_irq_enable_q;
  logic [5:0] hf_trim_field_q;
  logic [5:0] lf_div_q;
  logic sample_q;
  logic sample_tick;
  logic [2:0] mon_in_q;
  logic [2:0] mon_raw;
  logic sref_lf_q;
  logic sample_prev_q;
  logic [2:0] seen_low_q;
  logic [2:0] fail_det;
  logic [2:0] mon_en;
  logic [15:0] ost_q;
  logic ost_busy;
  logic armed_q;
  logic wake_q;
  cfmat_fs_type fs_q;
  logic [2:0] req_src_q;
  logic [3:0] req_div_q;
  logic [2:0] cur_src_q;
  logic req_change;
  logic sref_q;
  logic [15:0] ref_cnt_q;
  logic hf_q;
  logic [15:0] hf_cnt_q;
  logic act_tick;
  logic [15:0] err_abs;
  logic err_fast;
  logic lock_new;
  logic ors_new;

  assign req_wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign req_rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;

  // classic single cycle: ack one edge after the strobe, then drop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req_rd) begin
      unique case (wb_adr_i)
        `CFMAT_ADR_ACT: rdat_q <= {24'h00_0000,
          auto_trim_enable_q, auto_trim_update_disable_q, 2'h0,
          auto_trim_locked_q, 1'b0, auto_trim_out_of_range_q,
          1'b0};
        `CFMAT_ADR_TRIM: rdat_q <= {26'h000_0000, hf_trim_field_q};
        `CFMAT_ADR_FAIL: rdat_q <= {21'h00_0000, inject_q, 1'b0,
          auto_trim_irq_enable_q, auto_trim_irq_flag_q,
          osc_fail_irq_enable_q, osc_fail_irq_flag_q, fail_status_q};
        `CFMAT_ADR_SRC: rdat_q <= {24'h00_0000, 1'b0, cur_src_q,
          req_div_q};
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // fault injection controls, one per monitor, plus both interrupt enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inject_q <= 3'h0;
      osc_fail_irq_enable_q <= 1'b0;
      auto_trim_irq_enable_q <= 1'b0;
    end else if (req_wr && wb_adr_i == `CFMAT_ADR_FAIL) begin
      if (wb_sel_i[1]) begin
        inject_q <= wb_dat_i[`CFMAT_F_INJ +: 3];
      end
      if (wb_sel_i[0]) begin
        osc_fail_irq_enable_q <= wb_dat_i[`CFMAT_F_OSC_FAIL_IRQ_ENABLE];
        auto_trim_irq_enable_q <= wb_dat_i[`CFMAT_F_AUTO_TRIM_IRQ_ENABLE];
      end
    end
  end

  // monitor sample clock: lf oscillator divided by 64
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lf_div_q <= 6'h00;
      sample_q <= 1'b0;
    end else if (rose(internal_lf_osc_i, sref_lf_q)) begin
      lf_div_q <= lf_div_q + 6'h01;
      if (lf_div_q == (`CFMAT_LF_DIV >> 1) || lf_div_q == `CFMAT_LF_DIV) begin
        sample_q <= ~sample_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sref_lf_q <= 1'b0;
      sample_prev_q <= 1'b0;
      mon_in_q <= 3'h0;
    end else begin
      sref_lf_q <= internal_lf_osc_i;
      sample_prev_q <= sample_q;
      mon_in_q <= mon_raw;
    end
  end

  // a half sample period with no falling edge of the watched clock fails it
  assign sample_tick = sample_q != sample_prev_q;
  assign mon_en = {secondary_mon_en_i, primary_mon_en_i, sysclk_mon_en_i};
  assign mon_raw = {secondary_ext_osc_i, primary_ext_osc_i, sysclk_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_low_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sample_tick) begin
          seen_low_q[i] <= 1'b0;
        end else if (fell(mon_raw[i], mon_in_q[i]) && !inject_q[i]) begin
          seen_low_q[i] <= 1'b1; // injection blocks the edge latch
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      fail_det[i] = (sample_tick && !seen_low_q[i] && mon_en[i] && armed_q)
                    || (inject_q[i] && mon_en[i]);
    end
  end

  // startup timer gates detection in crystal modes after reset or wake
  assign ost_busy = ost_q != 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ost_q <= `CFMAT_OST_CYC;
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_i;
      if (rose(wake_i, wake_q) || (req_change &&
          (requested_source_sel_i == `CFMAT_SRC_EXT ||
           requested_source_sel_i == `CFMAT_SRC_PLL))) begin
        ost_q <= `CFMAT_OST_CYC;
      end else if (ost_busy) begin
        ost_q <= ost_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (sleep_i) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= (cfmat_mode_type'(ext_osc_mode_i) == CFMAT_XT_EC)
                 || !ost_busy;
    end
  end

  // sticky status; hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_status_q <= 3'h0;
      osc_fail_irq_flag_q <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (fail_det[i]) begin
          fail_status_q[i] <= 1'b1;
        end else if (req_wr && wb_adr_i == `CFMAT_ADR_FAIL && wb_sel_i[0]
                     && !wb_dat_i[i]) begin
          fail_status_q[i] <= 1'b0;
        end
      end
      if (|fail_det) begin
        osc_fail_irq_flag_q <= 1'b1;
      end else if (req_wr && wb_adr_i == `CFMAT_ADR_FAIL && wb_sel_i[0]
                   && !wb_dat_i[`CFMAT_F_OSC_FAIL_IRQ_FLAG]) begin
        osc_fail_irq_flag_q <= 1'b0;
      end
    end
  end

  // fail-safe state: only the system clock monitor switches sources
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_src_q <= `CFMAT_SRC_HF;
      req_div_q <= 4'h0;
    end else begin
      req_src_q <= requested_source_sel_i;
      req_div_q <= requested_divider_sel_i;
    end
  end

  assign req_change = requested_source_sel_i != req_src_q
                      || requested_divider_sel_i != req_div_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_q <= CFMAT_RUN;
    end else begin
      unique case (fs_q)
        CFMAT_RUN: if (fail_det[`CFMAT_F_SYS]) fs_q <= CFMAT_FAILED;
        CFMAT_FAILED: begin
          if (sleep_i) begin
            fs_q <= CFMAT_RUN;
          end else if (req_change) begin
            fs_q <= CFMAT_WAIT_OST;
          end
        end
        CFMAT_WAIT_OST: begin
          if (fail_det[`CFMAT_F_SYS]) begin
            fs_q <= CFMAT_FAILED;
          end else if (!ost_busy && switch_done_i) begin
            fs_q <= CFMAT_RUN;
          end
        end
        default: fs_q <= CFMAT_RUN;
      endcase
    end
  end

  // forced source keeps prior frequency and divider settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_src_q <= `CFMAT_SRC_HF;
    end else if (fs_q != CFMAT_RUN || fail_det[`CFMAT_F_SYS]) begin
      cur_src_q <= `CFMAT_SRC_HF;
    end else if (switch_done_i) begin
      cur_src_q <= req_src_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsafe_force_hf_o <= 1'b0;
      osc_fail_irq_o <= 1'b0;
      auto_trim_irq_o <= 1'b0;
    end else begin
      fsafe_force_hf_o <= fs_q != CFMAT_RUN;
      osc_fail_irq_o <= osc_fail_irq_flag_q & osc_fail_irq_enable_q;
      auto_trim_irq_o <= auto_trim_irq_flag_q & auto_trim_irq_enable_q;
    end
  end

  assign current_source_sel_o = cur_src_q;

  // auto trim: count hf edges over a window of 32.768 kHz reference edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sref_q <= 1'b0;
      hf_q <= 1'b0;
    end else begin
      sref_q <= secondary_ext_osc_i;
      hf_q <= internal_hf_osc_i;
    end
  end

  assign act_tick = auto_trim_enable_q && rose(secondary_ext_osc_i, sref_q)
                    && ref_cnt_q == `CFMAT_REF_WIN - 16'h0001;

  always_ff @(posedge clk_i) begin
    if (rst_i || !auto_trim_enable_q) begin
      ref_cnt_q <= 16'h0000;
      hf_cnt_q <= 16'h0000;
    end else begin
      if (rose(secondary_ext_osc_i, sref_q)) begin
        ref_cnt_q <= act_tick ? 16'h0000 : ref_cnt_q + 16'h0001;
      end
      if (act_tick) begin
        hf_cnt_q <= 16'h0000;
      end else if (rose(internal_hf_osc_i, hf_q)) begin
        hf_cnt_q <= hf_cnt_q + 16'h0001;
      end
    end
  end

  // target ratio equals the window; tolerance is about 1 percent of it
  assign err_fast = hf_cnt_q > `CFMAT_REF_WIN;
  assign err_abs = err_fast ? hf_cnt_q - `CFMAT_REF_WIN
                            : `CFMAT_REF_WIN - hf_cnt_q;
  assign lock_new = err_abs <= `CFMAT_LOCK_TOL;
  assign ors_new = !lock_new &&
    ((err_fast && hf_trim_field_q == `CFMAT_TRIM_MIN) ||
     (!err_fast && hf_trim_field_q == `CFMAT_TRIM_MAX));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_trim_enable_q <= 1'b0;
      auto_trim_update_disable_q <= 1'b0;
    end else if (req_wr && wb_adr_i == `CFMAT_ADR_ACT && wb_sel_i[0]) begin
      auto_trim_enable_q <= wb_dat_i[`CFMAT_ACT_EN];
      auto_trim_update_disable_q <= wb_dat_i[`CFMAT_ACT_UD];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !auto_trim_enable_q) begin
      auto_trim_locked_q <= 1'b0;
      auto_trim_out_of_range_q <= 1'b0;
    end else if (act_tick) begin
      auto_trim_locked_q <= lock_new;
      auto_trim_out_of_range_q <= ors_new;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_trim_irq_flag_q <= 1'b0;
    end else if (act_tick && (lock_new != auto_trim_locked_q
                 || ors_new != auto_trim_out_of_range_q)) begin
      auto_trim_irq_flag_q <= 1'b1;
    end else if (req_wr && wb_adr_i == `CFMAT_ADR_FAIL && wb_sel_i[0]
                 && !wb_dat_i[`CFMAT_F_AUTO_TRIM_IRQ_FLAG]) begin
      auto_trim_irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hf_trim_field_q <= `CFMAT_TRIM_RST;
    end else if (auto_trim_enable_q) begin
      if (act_tick && !auto_trim_update_disable_q && !lock_new
          && !ors_new) begin
        hf_trim_field_q <= err_fast ? hf_trim_field_q - 6'h01
                                    : hf_trim_field_q + 6'h01;
      end
    end else if (req_wr && wb_adr_i == `CFMAT_ADR_TRIM && wb_sel_i[0]
                 && !auto_trim_update_disable_q) begin
      hf_trim_field_q <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hf_trim_field_o <= `CFMAT_TRIM_RST;
    end else begin
      hf_trim_field_o <= hf_trim_field_q;
    end
  end

endmodule : cfmat_top

// ===== testbench/cfmat_osc_model.sv
// stand-in for the crystal, reference and internal oscillator sources
// assumes the block samples every source as a level on clk_i
`timescale 1ns/1ps
module cfmat_osc_model (
  input wire logic clk_i,
  input wire logic stop_pri_i,
  input wire logic stop_hf_i,
  output logic sys_o,
  output logic pri_o,
  output logic sec_o,
  output logic lf_o,
  output logic hf_o
);
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge clk_i) begin
    cnt_q <= cnt_q + 4'h1;
  end
  assign sys_o = cnt_q[1];
  // a dead crystal sits high, so no falling edge reaches the monitor
  assign pri_o = stop_pri_i ? 1'b1 : cnt_q[1];
  // scaled-down reference; the real one is far slower than clk_i
  assign sec_o = cnt_q[2];
  assign lf_o = cnt_q[0];
  assign hf_o = stop_hf_i ? 1'b1 : cnt_q[0];
endmodule : cfmat_osc_model

// ===== testbench/cfmat_top_sva.sv
// port-level assertions for the fail monitor and trim block
// assumes one clk_i domain with rst_i synchronous and active high
`include "cfmat_consts.svh"
`timescale 1ns/1ps
module cfmat_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic sysclk_mon_en_i,
  input wire logic sleep_i,
  input wire logic [2:0] requested_source_sel_i,
  input wire logic [3:0] requested_divider_sel_i,
  input wire logic fsafe_force_hf_o,
  input wire logic [2:0] current_source_sel_o,
  input wire logic osc_fail_irq_o,
  input wire logic auto_trim_irq_o,
  input wire logic [5:0] hf_trim_field_o
);
  logic [7:0] req_now;
  logic [7:0] req_q;
  logic [7:0] req_qq;
  logic chg_q;
  logic inj_wr;
  assign req_now = {sleep_i, requested_source_sel_i, requested_divider_sel_i};
  assign inj_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
    wb_adr_i == `CFMAT_ADR_FAIL && wb_dat_i[`CFMAT_F_INJ];
  // remembers a request change since failover; the exit may wait on a timer
  always_ff @(posedge clk_i) begin
    req_q <= req_now;
    req_qq <= req_q;
    if (rst_i || !fsafe_force_hf_o) begin
      chg_q <= 1'b0;
    end else if (req_now != req_q) begin
      chg_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_rst_vals;
    disable iff (1'b0) $past(rst_i) && !rst_i |->
      hf_trim_field_o == `CFMAT_TRIM_RST && !fsafe_force_hf_o &&
      current_source_sel_o == `CFMAT_SRC_HF;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not at reset values");
  property p_force_src;
    fsafe_force_hf_o && $past(fsafe_force_hf_o) |->
      current_source_sel_o == `CFMAT_SRC_HF;
  endproperty
  a_force_src: assert property (p_force_src)
    else $error("fail-safe active but source not internal");
  property p_stay_hf;
    fsafe_force_hf_o && !chg_q && req_now == req_q && req_q == req_qq
      |=> fsafe_force_hf_o;
  endproperty
  a_stay_hf: assert property (p_stay_hf)
    else $error("fail-safe left without request change");
  property p_sleep_clr;
    fsafe_force_hf_o && sleep_i |-> ##[1:4] !fsafe_force_hf_o;
  endproperty
  a_sleep_clr: assert property (p_sleep_clr)
    else $error("sleep did not clear fail-safe");
  property p_inj_force;
    inj_wr && sysclk_mon_en_i |-> ##[1:1000] fsafe_force_hf_o;
  endproperty
  a_inj_force: assert property (p_inj_force)
    else $error("system injection gave no failover");
  property p_act_rsvd;
    wb_ack_o && $past(wb_adr_i) == `CFMAT_ADR_ACT && !$past(wb_we_i) |->
      wb_dat_o[5:4] == 2'h0 && !wb_dat_o[2] && !wb_dat_o[0];
  endproperty
  a_act_rsvd: assert property (p_act_rsvd)
    else $error("unused tuning control bits read nonzero");
  property p_osf_hold;
    osc_fail_irq_o && !(wb_cyc_i && wb_we_i) |=> osc_fail_irq_o;
  endproperty
  a_osf_hold: assert property (p_osf_hold)
    else $error("fail interrupt dropped without a write");
  property p_act_hold;
    auto_trim_irq_o && !(wb_cyc_i && wb_we_i) |=> auto_trim_irq_o;
  endproperty
  a_act_hold: assert property (p_act_hold)
    else $error("tuning interrupt dropped without a write");
  c_fsafe: cover property ($rose(fsafe_force_hf_o));
  c_osf: cover property ($rose(osc_fail_irq_o));
  c_act: cover property ($rose(auto_trim_irq_o));
endmodule : cfmat_top_sva
bind cfmat_top cfmat_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .sysclk_mon_en_i(sysclk_mon_en_i),
  .sleep_i(sleep_i), .requested_source_sel_i(requested_source_sel_i),
  .requested_divider_sel_i(requested_divider_sel_i),
  .fsafe_force_hf_o(fsafe_force_hf_o),
  .current_source_sel_o(current_source_sel_o),
  .osc_fail_irq_o(osc_fail_irq_o), .auto_trim_irq_o(auto_trim_irq_o),
  .hf_trim_field_o(hf_trim_field_o));

// ===== testbench/cfmat_top_tb.sv
// register-level bench for the fail monitor and trim block
// assumes 0xAC/0xB0/0xC0/0xC4 map and crystal mode, so detection waits
`timescale 1ns/1ps
module cfmat_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hF;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic sys, pri, sec, lf, hf, fsafe, osf_irq, act_irq;
  logic stop_pri = 1'b1;
  logic stop_hf = 1'b0;
  logic sleep_i = 1'b0;
  logic [2:0] req_src = 3'h7;
  logic [3:0] req_div = 4'h0;
  logic sw_done = 1'b0;
  logic [2:0] cur_src;
  logic [5:0] trim;
  logic [31:0] rd;
  int err_total = 0;
  int comparisons = 0;
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  cfmat_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .sysclk_i(sys), .primary_ext_osc_i(pri),
    .secondary_ext_osc_i(sec), .internal_lf_osc_i(lf),
    .internal_hf_osc_i(hf), .sysclk_mon_en_i(1'b1),
    .primary_mon_en_i(1'b1), .secondary_mon_en_i(1'b1),
    .ext_osc_mode_i(2'b01), .sleep_i(sleep_i), .wake_i(1'b0),
    .requested_source_sel_i(req_src), .requested_divider_sel_i(req_div),
    .switch_done_i(sw_done), .fsafe_force_hf_o(fsafe),
    .current_source_sel_o(cur_src), .osc_fail_irq_o(osf_irq),
    .auto_trim_irq_o(act_irq), .hf_trim_field_o(trim));
  cfmat_osc_model u_osc (.clk_i(clk_i), .stop_pri_i(stop_pri),
    .stop_hf_i(stop_hf), .sys_o(sys), .pri_o(pri), .sec_o(sec),
    .lf_o(lf), .hf_o(hf));
  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      n++;
      if (n > 16) begin
        err_total++;
        $display("ERROR ack expected 1 seen %b", wb_ack_o);
        end_of_test;
      end
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // reads until every bit of m is set; a bound that runs out is a mismatch
  task poll(input logic [7:0] a, input logic [31:0] m, input int bound);
    int n;
    n = 0;
    wb(a, 1'b0, 32'h0);
    while ((rd & m) !== m && n < bound) begin
      wb(a, 1'b0, 32'h0);
      n++;
    end
    chk("poll", rd & m, m);
  endtask : poll
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(8'hAC, 1'b0, 32'h0); chk("act_rst", rd, 32'h0);
    wb(8'hB0, 1'b0, 32'h0); chk("trim_rst", rd, 32'h0);
    // primary dead from reset, but the startup timer still masks it
    repeat (200) @(posedge clk_i);
    wb(8'hC0, 1'b0, 32'h0); chk("fail_rst", rd, 32'h0);
    stop_pri <= 1'b0;
    wb(8'hB0, 1'b1, 32'h1F);
    wb(8'hB0, 1'b0, 32'h0); chk("trim_max", rd, 32'h1F);
    wb(8'hAC, 1'b1, 32'h4A);
    wb(8'hAC, 1'b0, 32'h0); chk("act_ro", rd, 32'h40);
    wb(8'hB0, 1'b1, 32'h20);
    wb(8'hB0, 1'b0, 32'h0); chk("trim_ud", rd, 32'h1F);
    wb(8'hAC, 1'b1, 32'h0);
    wb(8'hB0, 1'b1, 32'h20); chk("trim_min", trim, 32'h20);
    wb(8'hB0, 1'b1, 32'h1F);
    sw_done <= 1'b1;
    poll(8'hC4, 32'h70, 1500);
    sw_done <= 1'b0;
    // a dead primary crystal only flags; the clock must not move
    wb(8'hC0, 1'b1, 32'h10);
    stop_pri <= 1'b1;
    poll(8'hC0, 32'h0A, 500);
    chk("osf_irq", osf_irq, 32'h1);
    chk("pri_no_sw", {fsafe, cur_src}, 32'h7);
    stop_pri <= 1'b0;
    repeat (300) @(posedge clk_i);
    wb(8'hC0, 1'b0, 32'h0); chk("pri_keep", rd & 32'h2, 32'h2);
    wb(8'hC0, 1'b1, 32'h10);
    wb(8'hC0, 1'b0, 32'h0); chk("pri_clr", rd, 32'h10);
    wb(8'hC0, 1'b1, 32'h410);
    poll(8'hC0, 32'h0C, 500);
    chk("sec_no_sw", {fsafe, cur_src}, 32'h7);
    wb(8'hC0, 1'b1, 32'h14);
    repeat (300) @(posedge clk_i);
    wb(8'hC0, 1'b0, 32'h0); chk("sec_keep", rd & 32'h404, 32'h4);
    wb(8'hC0, 1'b1, 32'h110);
    poll(8'hC0, 32'h09, 500);
    chk("failover", {fsafe, cur_src}, 32'hE);
    wb(8'hC0, 1'b1, 32'h19);
    repeat (300) @(posedge clk_i);
    chk("stay_hf", {fsafe, cur_src}, 32'hE);
    wb(8'hC0, 1'b1, 32'h10);
    wb(8'hC0, 1'b0, 32'h0); chk("osf_clr", rd & 32'h9, 32'h0);
    req_div <= 4'h1;
    sw_done <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk("ost_hold", cur_src, 32'h6);
    poll(8'hC4, 32'h70, 1500);
    sw_done <= 1'b0;
    chk("req_clr", fsafe, 32'h0);
    wb(8'hC0, 1'b1, 32'h110);
    poll(8'hC0, 32'h09, 500);
    wb(8'hC0, 1'b1, 32'h10);
    sleep_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    sleep_i <= 1'b0;
    chk("sleep_clr", fsafe, 32'h0);
    // a stalled oscillator asks for more than the top trim step
    stop_hf <= 1'b1;
    wb(8'hC0, 1'b1, 32'h50);
    wb(8'hAC, 1'b1, 32'h80);
    poll(8'hC0, 32'h20, 12000);
    chk("act_irq", act_irq, 32'h1);
    wb(8'hAC, 1'b0, 32'h0); chk("ors", rd, 32'h82);
    wb(8'hB0, 1'b1, 32'h05);
    wb(8'hB0, 1'b0, 32'h0); chk("trim_hold", rd, 32'h1F);
    wb(8'hAC, 1'b1, 32'h0);
    wb(8'hAC, 1'b0, 32'h0); chk("lock_off", rd & 32'h8, 32'h0);
    end_of_test;
  end
endmodule : cfmat_top_tb
